// >>> src/icms_top.v
/*
 Input clock monitor and selector for one channel: AXI4-Lite registers,
 three monitored inputs, priority table and reference choice.
 Assumes references and pins are asynchronous and slow enough after
 two-flop sampling at the master clock; the lock flag is same-domain.
*/
// How it works
// - Each input divides and tracks the edge its edge_select bit picks, rising default.
// - Activity monitor counts divided edges per interval, verdict in activity_ok.
// - No toggling or too fast keeps activity_ok low; too slow flickers it.
// - Percent monitor compares count to nominal within a 1 to 20 percent bound.
// - Input good shows live; any change of it sets its sticky bit.
// - Inputs cleared in input_allow_mask are never auto selected.
// - Monitor on bits switch each monitor; off means good unless pin loss or activity failure forces it bad.
// - Chosen input not locked within lock_timeout_limit gets lock_timeout_flag.
// - Any pin may be an input's loss source; code 010 picks pin one.
// - Pin function code 0001 inverts the pin for active low loss.
// - Pin loss forces both monitors bad; activity failure forces percent bad.
// - All monitors good must hold for validation time before qualified.
// - Priority 0 excludes an input; 1 highest; reset priorities 1, 2, 3.
// - Automatic mode picks the best qualified input and shows a priority table.
// - Equal priorities rotate circularly, skip failed ones, never return_to_best.
// - Return_to_best mode switches to better inputs at once; failure always switches.
// - Pin mode: high picks input one, or three if one has priority 0; low two.
// - Pin mode overrides the chosen reference and holds ref valid high; best keeps tracking.
// - Each input runs only while its input_enable_mask bit is set.
`timescale 1ns/1ps
`include "icms_defs.vh"
module icms_top (
  // Clock and reset
  input wire I_CLK,
  input wire I_RESET_N,
  // AXI4-Lite write address and data
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  // AXI4-Lite write response
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  // AXI4-Lite read
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  // Reference inputs and general-purpose pins
  input wire [2:0] I_REF_CLK,
  input wire [3:0] I_GPIO,
  // Loop interface
  input wire I_DPLL_LOCKED,
  output reg [1:0] O_CHOSEN_REF,
  output reg [1:0] O_BEST_CAND,
  output reg O_REF_VALID,
  output reg O_REF_EDGE,
  output reg [2:0] O_INPUT_POWER
);
  // ==========================================================
  // Configuration storage
  reg [31:0] cfg_q [0:`ICMS_NUM_CFG-1];
  reg [2:0] sticky_q;
  reg [2:0] lock_timeout_flag_q;
  reg [2:0] good_prev_q;
  // Own loop indices per process so no variable has two drivers
  integer k;
  integer m;
  integer p;

  function [31:0] cfg_mask;
    input [3:0] idx;
    begin
      case ({idx, 2'b00})
        `ICMS_OFF_CTRL: cfg_mask = `ICMS_MASK_CTRL;
        `ICMS_OFF_PRIO: cfg_mask = `ICMS_MASK_PRIO;
        `ICMS_OFF_LOSS: cfg_mask = `ICMS_MASK_LOSS;
        `ICMS_OFF_GPIO: cfg_mask = `ICMS_MASK_GPIO;
        `ICMS_OFF_PCT: cfg_mask = `ICMS_MASK_PCT;
        `ICMS_OFF_LOCK_TIMEOUT_FLAG: cfg_mask = `ICMS_MASK_24;
        `ICMS_OFF_DIV: cfg_mask = `ICMS_MASK_24;
        default: cfg_mask = `ICMS_MASK_16;
      endcase
    end
  endfunction

  function [31:0] cfg_rst;
    input [3:0] idx;
    begin
      case ({idx, 2'b00})
        `ICMS_OFF_CTRL: cfg_rst = `ICMS_RST_CTRL;
        `ICMS_OFF_PRIO: cfg_rst = `ICMS_RST_PRIO;
        `ICMS_OFF_INTV: cfg_rst = `ICMS_RST_INTV;
        `ICMS_OFF_ACTMAX: cfg_rst = `ICMS_RST_ACTMAX;
        `ICMS_OFF_EXP1: cfg_rst = `ICMS_RST_EXP;
        `ICMS_OFF_EXP2: cfg_rst = `ICMS_RST_EXP;
        `ICMS_OFF_EXP3: cfg_rst = `ICMS_RST_EXP;
        `ICMS_OFF_PCT: cfg_rst = `ICMS_RST_PCT;
        `ICMS_OFF_QUALIFIED_AFTER_TIMER: cfg_rst = `ICMS_RST_QUALIFIED_AFTER_TIMER;
        `ICMS_OFF_LOCK_TIMEOUT_FLAG: cfg_rst = `ICMS_RST_LOCK_TIMEOUT_FLAG;
        default: cfg_rst = 32'h0000_0000;
      endcase
    end
  endfunction

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer b;
    begin
      strb_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (st[b]) begin
          strb_merge[8*b +: 8] = wd[8*b +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrl = cfg_q[0];
  wire [11:0] prio = cfg_q[1][11:0];
  wire [8:0] loss_src = cfg_q[2][8:0];
  wire [15:0] gpio_fn = cfg_q[3][15:0];
  wire [2:0] en = ctrl[`ICMS_CTRL_EN +: 3];
  wire ext_sw = ctrl[`ICMS_CTRL_PIN_DRIVEN_SWITCH];
  wire return_to_best = ctrl[`ICMS_CTRL_RETURN_TO_BEST];
  wire [1:0] pin_sel = ctrl[`ICMS_CTRL_PINSEL +: 2];
  wire [2:0] allow = ctrl[`ICMS_CTRL_ALLOW +: 3];

  // ==========================================================
  // AXI4-Lite slave
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_full_q;
  reg w_full_q;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire wr_fire = aw_full_q && w_full_q && !O_BVALID;
  wire [3:0] wr_idx = aw_addr_q[5:2];
  wire wr_cfg = wr_fire && (aw_addr_q < 8'h34) && (aw_addr_q[1:0] == 2'b00);
  wire wr_good = wr_fire && (aw_addr_q == `ICMS_OFF_GOOD);

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `ICMS_RESP_OK;
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `ICMS_RESP_OK;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_addr_q <= I_AWADDR;
        aw_full_q <= 1'b1;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
        w_full_q <= 1'b1;
        O_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (wr_cfg || wr_good) ? `ICMS_RESP_OK : `ICMS_RESP_ERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RDATA <= rd_hit ? rd_mux : 32'h0000_0000;
        O_RRESP <= rd_hit ? `ICMS_RESP_OK : `ICMS_RESP_ERR;
      end
      if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      for (m = 0; m < `ICMS_NUM_CFG; m = m + 1) begin
        cfg_q[m] <= cfg_rst(m[3:0]);
      end
    end else if (wr_cfg) begin
      cfg_q[wr_idx] <= strb_merge(cfg_q[wr_idx], w_data_q, w_strb_q) & cfg_mask(wr_idx);
    end
  end

  // ==========================================================
  // Pin sampling and loss sources
  wire [6:0] synced;
  icms_sync #(.W(7)) u_sync (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_async({I_GPIO, I_REF_CLK}),
    .o_sync(synced)
  );
  reg [3:0] pin_lvl;
  reg [2:0] los;

  function los_pick;
    input [2:0] code;
    input [3:0] pins;
    reg [2:0] n;
    begin
      n = code - `ICMS_LOS_PIN_BASE;
      los_pick = (code >= `ICMS_LOS_PIN_BASE) && (code <= `ICMS_LOS_PIN_LAST) &&
                 pins[n[1:0]];
    end
  endfunction

  always @* begin
    for (p = 0; p < 4; p = p + 1) begin
      pin_lvl[p] = synced[3+p] ^ (gpio_fn[4*p +: 4] == `ICMS_GPIO_FN_INV);
    end
    for (p = 0; p < 3; p = p + 1) begin
      los[p] = los_pick(loss_src[3*p +: 3], pin_lvl);
    end
  end

  // ==========================================================
  // Interval tick and per-input monitors
  reg [15:0] intv_cnt_q;
  wire tick = (intv_cnt_q >= cfg_q[4][15:0]);
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      intv_cnt_q <= 16'h0000;
    end else begin
      intv_cnt_q <= tick ? 16'h0000 : intv_cnt_q + 16'h0001;
    end
  end

  wire [2:0] m_edge;
  wire [2:0] m_act;
  wire [2:0] m_pct;
  wire [2:0] m_good;
  wire [2:0] m_qual;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_mon
      icms_mon u_mon (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_ref(synced[g]),
        .i_los(los[g]),
        .i_en(en[g]),
        .i_edge_sel(ctrl[`ICMS_CTRL_EDGE + g]),
        .i_div(cfg_q[12][8*g +: 8]),
        .i_act_on(ctrl[`ICMS_CTRL_ACTON + g]),
        .i_pct_on(ctrl[`ICMS_CTRL_PCTON + g]),
        .i_tick(tick),
        .i_act_max(cfg_q[5][15:0]),
        .i_exp(cfg_q[6+g][15:0]),
        .i_pct(cfg_q[9][5*g +: 5]),
        .i_valtime(cfg_q[10][15:0]),
        .o_edge(m_edge[g]),
        .o_act_ok(m_act[g]),
        .o_pct_ok(m_pct[g]),
        .o_all_good(m_good[g]),
        .o_qual(m_qual[g])
      );
    end
  endgenerate

  // ==========================================================
  // Selection: keys, priority table, chosen reference
  reg [1:0] chosen_q;
  reg [1:0] best_q;
  reg [7:0] ptab_q;
  reg [5:0] key [0:2];
  reg [2:0] elig;
  reg [1:0] rank [0:2];
  reg [1:0] best_c;
  reg [5:0] tab_c;
  reg [1:0] next_c;
  reg [1:0] cur_i;
  reg [1:0] pin_ref;
  integer j;
  wire [2:0] good_now = m_good & ~lock_timeout_flag_q;

  // Current input ties first, then onward around the circle
  function [5:0] sel_key;
    input ok;
    input [3:0] pr;
    input [1:0] idx;
    input [1:0] cur;
    reg [2:0] d;
    begin
      d = {1'b0, idx} + 3'd2 - {1'b0, cur};
      if (d >= 3'd3) begin
        d = d - 3'd3;
      end
      sel_key = !ok ? 6'h3F : (idx == cur) ? {pr, 2'b00} : {pr, d[1:0] + 2'b01};
    end
  endfunction

  always @* begin
    cur_i = (chosen_q == 2'b00) ? 2'd2 : chosen_q - 2'd1;
    for (k = 0; k < 3; k = k + 1) begin
      elig[k] = m_qual[k] && allow[k] && en[k] && !lock_timeout_flag_q[k] &&
                (prio[4*k +: 4] != 4'h0);
      key[k] = sel_key(elig[k], prio[4*k +: 4], k[1:0], cur_i);
    end
    tab_c = 6'h00;
    for (k = 0; k < 3; k = k + 1) begin
      rank[k] = 2'd0;
      for (j = 0; j < 3; j = j + 1) begin
        if (key[j] < key[k] || (key[j] == key[k] && j < k)) begin
          rank[k] = rank[k] + 2'd1;
        end
      end
      if (elig[k]) begin
        tab_c[2*rank[k] +: 2] = k[1:0] + 2'd1;
      end
    end
    best_c = tab_c[1:0];
    next_c = chosen_q;
    if (chosen_q == 2'b00 || !elig[cur_i]) begin
      next_c = best_c;
    end else if (return_to_best && best_c != 2'b00 &&
                 prio[4*(best_c-2'd1) +: 4] < prio[4*cur_i +: 4]) begin
      next_c = best_c;
    end
    pin_ref = pin_lvl[pin_sel] ? ((prio[3:0] != 4'h0) ? 2'd1 : 2'd3) : 2'd2;
    if (ext_sw) begin
      next_c = pin_ref;
    end
  end

  // ==========================================================
  // Lock timeout and sticky flags
  reg [23:0] lk_cnt_q;
  wire lk_run = (chosen_q != 2'b00) && !I_DPLL_LOCKED && (next_c == chosen_q);
  wire lk_hit = lk_run && (lk_cnt_q >= cfg_q[11][23:0]);
  wire [2:0] lk_set = lk_hit ? (3'b001 << cur_i) : 3'b000;
  wire [2:0] sticky_clr = wr_good ? w_data_q[`ICMS_GOOD_STICKY +: 3] : 3'b000;
  wire [2:0] lock_timeout_flag_clr = wr_good ? w_data_q[`ICMS_GOOD_LOCK_TIMEOUT_FLAG +: 3] : 3'b000;

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      chosen_q <= 2'b00;
      best_q <= 2'b00;
      ptab_q <= 8'h00;
      lk_cnt_q <= 24'h00_0000;
      lock_timeout_flag_q <= 3'b000;
      sticky_q <= 3'b000;
      good_prev_q <= 3'b000;
      O_CHOSEN_REF <= 2'b00;
      O_BEST_CAND <= 2'b00;
      O_REF_VALID <= 1'b0;
      O_REF_EDGE <= 1'b0;
      O_INPUT_POWER <= 3'b000;
    end else begin
      chosen_q <= next_c;
      best_q <= best_c;
      ptab_q <= {tab_c[5:2], next_c, best_c};
      lk_cnt_q <= (lk_run && !lk_hit) ? lk_cnt_q + 24'h00_0001 : 24'h00_0000;
      lock_timeout_flag_q <= (lock_timeout_flag_q & ~lock_timeout_flag_clr) | lk_set;
      good_prev_q <= good_now;
      sticky_q <= (sticky_q & ~sticky_clr) | (good_now ^ good_prev_q);
      O_CHOSEN_REF <= next_c;
      O_BEST_CAND <= best_c;
      O_REF_VALID <= (next_c != 2'b00) && (ext_sw || elig[next_c - 2'd1]);
      O_REF_EDGE <= (next_c != 2'b00) && m_edge[next_c - 2'd1];
      O_INPUT_POWER <= en;
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (I_ARADDR < 8'h34 && I_ARADDR[1:0] == 2'b00) begin
      rd_mux = cfg_q[I_ARADDR[5:2]];
    end else begin
      case (I_ARADDR)
        `ICMS_OFF_MSTAT: begin
          rd_mux = {12'h000, lock_timeout_flag_q, m_qual, m_good, los, m_pct, m_act};
        end
        `ICMS_OFF_GOOD: begin
          rd_mux = {21'h00_0000, lock_timeout_flag_q, 1'b0, sticky_q, 1'b0, good_now};
        end
        `ICMS_OFF_PTAB: begin
          rd_mux = {24'h00_0000, ptab_q};
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> include/icms_defs.vh
/*
 Constants of the input clock monitor and selector: register offsets,
 field positions, write masks, reset values and monitor limits.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ICMS_DEFS_VH
`define ICMS_DEFS_VH
// ==========================================================
// Register byte offsets
`define ICMS_OFF_CTRL 8'h00
`define ICMS_OFF_PRIO 8'h04
`define ICMS_OFF_LOSS 8'h08
`define ICMS_OFF_GPIO 8'h0C
`define ICMS_OFF_INTV 8'h10
`define ICMS_OFF_ACTMAX 8'h14
`define ICMS_OFF_EXP1 8'h18
`define ICMS_OFF_EXP2 8'h1C
`define ICMS_OFF_EXP3 8'h20
`define ICMS_OFF_PCT 8'h24
`define ICMS_OFF_QUALIFIED_AFTER_TIMER 8'h28
`define ICMS_OFF_LOCK_TIMEOUT_FLAG 8'h2C
`define ICMS_OFF_DIV 8'h30
`define ICMS_OFF_MSTAT 8'h40
`define ICMS_OFF_GOOD 8'h44
`define ICMS_OFF_PTAB 8'h48
`define ICMS_NUM_CFG 13
// ==========================================================
// Control register fields
`define ICMS_CTRL_EN 0
`define ICMS_CTRL_PIN_DRIVEN_SWITCH 3
`define ICMS_CTRL_RETURN_TO_BEST 4
`define ICMS_CTRL_PINSEL 5
`define ICMS_CTRL_EDGE 7
`define ICMS_CTRL_ACTON 10
`define ICMS_CTRL_PCTON 13
`define ICMS_CTRL_ALLOW 16
// Good/sticky register fields
`define ICMS_GOOD_STICKY 4
`define ICMS_GOOD_LOCK_TIMEOUT_FLAG 8
// ==========================================================
// Write masks and reset values
`define ICMS_MASK_CTRL 32'h0007_FFFF
`define ICMS_RST_CTRL 32'h0007_FC07
`define ICMS_MASK_PRIO 32'h0000_0FFF
`define ICMS_RST_PRIO 32'h0000_0321
`define ICMS_MASK_LOSS 32'h0000_01FF
`define ICMS_MASK_GPIO 32'h0000_FFFF
`define ICMS_MASK_16 32'h0000_FFFF
`define ICMS_RST_INTV 32'h0000_03E8
`define ICMS_RST_ACTMAX 32'h0000_FFFF
`define ICMS_RST_EXP 32'h0000_01F4
`define ICMS_MASK_PCT 32'h0000_7FFF
`define ICMS_RST_PCT 32'h0000_14A5
`define ICMS_RST_QUALIFIED_AFTER_TIMER 32'h0000_0064
`define ICMS_MASK_24 32'h00FF_FFFF
`define ICMS_RST_LOCK_TIMEOUT_FLAG 32'h000F_4240
// ==========================================================
// Codes and limits
`define ICMS_GPIO_FN_INV 4'h1
`define ICMS_LOS_PIN_BASE 3'h2
`define ICMS_LOS_PIN_LAST 3'h5
`define ICMS_PCT_MIN 5'h01
`define ICMS_PCT_MAX 5'h14
`define ICMS_PCT_SCALE 24'h00_0064
`define ICMS_RESP_OK 2'h0
`define ICMS_RESP_ERR 2'h2
`endif

// >>> src/icms_sync.v
/*
 Two-flop synchronizer for a group of asynchronous pins.
 Assumes each bit is an independent level; no bus coherence across bits.
*/
`timescale 1ns/1ps
module icms_sync #(
  parameter W = 7
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Pins in, synchronized levels out
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// >>> src/icms_mon.v
/*
 Per-input edge select, prescaler, activity and percent monitors with
 hierarchy and validation timer.
 Assumes a synchronized reference level and a shared interval tick.
*/
`timescale 1ns/1ps
`include "icms_defs.vh"
module icms_mon (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Reference and pin loss
  input wire i_ref,
  input wire i_los,
  // Configuration
  input wire i_en,
  input wire i_edge_sel,
  input wire [7:0] i_div,
  input wire i_act_on,
  input wire i_pct_on,
  input wire i_tick,
  input wire [15:0] i_act_max,
  input wire [15:0] i_exp,
  input wire [4:0] i_pct,
  input wire [15:0] i_valtime,
  // Status
  output reg o_edge,
  output reg o_act_ok,
  output reg o_pct_ok,
  output reg o_all_good,
  output reg o_qual
);
  reg prev_q;
  reg [7:0] div_cnt_q;
  reg [15:0] cnt_q;
  reg act_raw_q;
  reg pct_raw_q;
  reg [15:0] val_cnt_q;
  wire raw_edge = i_edge_sel ? (prev_q & ~i_ref) : (~prev_q & i_ref);
  wire div_edge = raw_edge && (div_cnt_q == i_div);
  wire act_c = !i_los && (!i_act_on || act_raw_q);
  wire pct_c = act_c && (!i_pct_on || pct_raw_q);
  wire good_c = act_c && pct_c;

  function in_range;
    input [15:0] cnt;
    input [15:0] expv;
    input [4:0] pct;
    reg [15:0] diff;
    reg [4:0] p;
    begin
      diff = (cnt > expv) ? cnt - expv : expv - cnt;
      p = (pct < `ICMS_PCT_MIN) ? `ICMS_PCT_MIN :
          (pct > `ICMS_PCT_MAX) ? `ICMS_PCT_MAX : pct;
      in_range = ({8'h00, diff} * `ICMS_PCT_SCALE) <=
                 ({8'h00, expv} * {19'h0_0000, p});
    end
  endfunction

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_q <= 1'b0;
      div_cnt_q <= 8'h00;
      cnt_q <= 16'h0000;
      act_raw_q <= 1'b0;
      pct_raw_q <= 1'b0;
      val_cnt_q <= 16'h0000;
      o_edge <= 1'b0;
      o_act_ok <= 1'b0;
      o_pct_ok <= 1'b0;
      o_all_good <= 1'b0;
      o_qual <= 1'b0;
    end else if (!i_en) begin
      prev_q <= i_ref;
      div_cnt_q <= 8'h00;
      cnt_q <= 16'h0000;
      act_raw_q <= 1'b0;
      pct_raw_q <= 1'b0;
      val_cnt_q <= 16'h0000;
      o_edge <= 1'b0;
      o_act_ok <= 1'b0;
      o_pct_ok <= 1'b0;
      o_all_good <= 1'b0;
      o_qual <= 1'b0;
    end else begin
      prev_q <= i_ref;
      o_edge <= div_edge;
      if (raw_edge) begin
        div_cnt_q <= div_edge ? 8'h00 : div_cnt_q + 8'h01;
      end
      if (i_tick) begin
        cnt_q <= {15'h0000, div_edge};
        // Too slow gives empty intervals, hence a flickering verdict
        act_raw_q <= (cnt_q != 16'h0000) && (cnt_q <= i_act_max);
        // Percent check only counts intervals begun with activity good
        pct_raw_q <= act_c && in_range(cnt_q, i_exp, i_pct);
      end else if (div_edge && cnt_q != 16'hFFFF) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      o_act_ok <= act_c;
      o_pct_ok <= pct_c;
      o_all_good <= good_c;
      if (!good_c) begin
        val_cnt_q <= 16'h0000;
      end else if (val_cnt_q < i_valtime) begin
        val_cnt_q <= val_cnt_q + 16'h0001;
      end
      o_qual <= good_c && (val_cnt_q >= i_valtime);
    end
  end
endmodule

// >>> testbench/icms_sva.sv
/*
 Checker of icms_top: bus answer timing, holds and reference edge pulses.
 Assumes it is bound to icms_top and sees only its ports.
*/
`timescale 1ns/1ps
module icms_sva (
  // Clock and reset
  input wire I_CLK,
  input wire I_RESET_N,
  // Register bus
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire [1:0] O_BRESP,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire [1:0] O_RRESP,
  input wire O_RVALID,
  input wire I_RREADY,
  // Loop side
  input wire [1:0] O_CHOSEN_REF,
  input wire O_REF_EDGE
);
  // ==========
  // Properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_reset_idle: assert property ($rose(I_RESET_N) |->
    O_AWREADY && O_ARREADY && !O_BVALID && O_CHOSEN_REF == 2'h0) else $error("not idle");
  a_bvalid_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("rvalid dropped");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |=> !O_BVALID ##1 O_BVALID) else $error("write answer late");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_write_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write ready while busy");
  a_read_busy: assert property (O_RVALID |-> !O_ARREADY) else $error("read ready while busy");
  a_unmapped_read: assert property (I_ARVALID && O_ARREADY && I_ARADDR == 8'h34
    |=> O_RRESP == 2'h2 && O_RDATA == 32'h0000_0000) else $error("unmapped read");
  a_edge_pulse: assert property (O_REF_EDGE |=> !O_REF_EDGE)
    else $error("edge pulse too long");
  c_write: cover property (O_BVALID && I_BREADY);
  c_unmapped: cover property (O_RVALID && O_RRESP == 2'h2);
  c_edge: cover property (O_REF_EDGE);
  c_second: cover property (O_CHOSEN_REF == 2'h2);
endmodule
bind icms_top icms_sva i_icms_sva (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_CHOSEN_REF(O_CHOSEN_REF),
  .O_REF_EDGE(O_REF_EDGE));

// >>> testbench/icms_refsrc.sv
/*
 Three free reference sources, each switchable on, off or too fast.
 Assumes the bench drives run and speed controls.
*/
`timescale 1ns/1ps
module icms_refsrc (
  // Controls
  input wire [2:0] i_run,
  input wire [2:0] i_fast,
  // Reference clocks
  output wire [2:0] o_ref
);
  for (genvar g = 0; g < 3; g++) begin : g_src
    logic r = 1'b0;
    assign o_ref[g] = r;
    initial begin
      forever begin
        // Slightly unequal periods keep the sources out of phase
        #(i_fast[g] ? 60 : 100 + 3 * g);
        r = i_run[g] ? ~r : 1'b0;
      end
    end
  end
endmodule

// >>> testbench/icms_top_bench.sv
/*
 Self-checking bench of icms_top: register rows, then selection cases.
 Assumes icms_refsrc drives the reference pins.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module icms_top_bench;
  typedef struct packed {bit w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} icms_row_t;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, lock = 1;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q;
  logic [3:0] gpio = 4'hF;
  logic [2:0] run = 3'h7, fast = 3'h0;
  logic [1:0] rs;
  int err_total = 0, samples_checked = 0;
  wire awrdy, wrdy, bvalid, arrdy, rvalid;
  wire [1:0] bresp, rresp, chosen, best;
  wire [2:0] power, refc;
  wire [31:0] rdata;
  icms_row_t rows [14] = '{
    '{0, 8'h00, 32'h0007_FC07, 2'h0},
    '{0, 8'h04, 32'h0000_0321, 2'h0},
    '{0, 8'h34, 32'h0000_0000, 2'h2},
    '{1, 8'h40, 32'h0000_0001, 2'h2},
    '{1, 8'h10, 32'h0000_0063, 2'h0},
    '{1, 8'h18, 32'h0000_0005, 2'h0},
    '{1, 8'h1C, 32'h0000_0005, 2'h0},
    '{1, 8'h20, 32'h0000_0005, 2'h0},
    '{1, 8'h24, 32'h0000_5294, 2'h0},
    '{1, 8'h28, 32'h0000_0005, 2'h0},
    '{1, 8'h2C, 32'h0000_0032, 2'h0},
    '{1, 8'h0C, 32'h0000_0001, 2'h0},
    '{1, 8'h08, 32'h0000_0002, 2'h0},
    '{0, 8'h08, 32'h0000_0002, 2'h0}};
  icms_top i_icms_top (.I_CLK(clk), .I_RESET_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_REF_CLK(refc), .I_GPIO(gpio), .I_DPLL_LOCKED(lock), .O_CHOSEN_REF(chosen),
    .O_BEST_CAND(best), .O_REF_VALID(), .O_REF_EDGE(), .O_INPUT_POWER(power));
  icms_refsrc i_icms_refsrc (.i_run(run), .i_fast(fast), .o_ref(refc));
  // ==========
  // Bus and wait tasks
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (bvalid !== 1'b1);
    // Late ready makes the response wait one cycle
    bready <= 1;
    @(posedge clk);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 0;
    end while (rvalid !== 1'b1);
    rready <= 1;
    @(posedge clk);
    q = rdata; rs = rresp;
    rready <= 0;
  endtask
  task automatic wsig(input bit b, input [1:0] e);
    for (int n = 0; n < 3000 && (b ? best : chosen) !== e; n++) @(posedge clk);
    `CHK(b ? best : chosen, e)
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // Sequence
  always #5 clk = ~clk;
  initial begin
    #1_000_000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      if (!rows[i].w) `CHK(q, rows[i].d)
      `CHK(rs, rows[i].r)
    end
    wsig(0, 2'h1);
    wsig(1, 2'h1);
    wr(8'h00, 32'h0006_FC07);
    wsig(0, 2'h2);
    wr(8'h00, 32'h0007_FC07);
    wsig(1, 2'h1);
    `CHK(chosen, 2'h2)
    wr(8'h00, 32'h0007_FC17);
    wsig(0, 2'h1);
    wr(8'h44, 32'h0000_0770);
    gpio[0] <= 0;
    wsig(0, 2'h2);
    rd(8'h44);
    `CHK(q, 32'h0000_0016)
    rd(8'h40);
    `CHK(q, 32'h0000_6C76)
    gpio[0] <= 1;
    wsig(0, 2'h1);
    fast[0] <= 1;
    wsig(0, 2'h2);
    fast[0] <= 0;
    wsig(0, 2'h1);
    run[0] <= 0;
    wsig(0, 2'h2);
    wr(8'h00, 32'h0007_D817);
    wsig(0, 2'h1);
    run[0] <= 1;
    wr(8'h00, 32'h0007_FC2F);
    gpio[1] <= 0;
    wsig(0, 2'h2);
    wsig(1, 2'h1);
    gpio[1] <= 1;
    wsig(0, 2'h1);
    wr(8'h04, 32'h0000_0320);
    wsig(0, 2'h3);
    wr(8'h04, 32'h0000_0321);
    wr(8'h00, 32'h0007_FC17);
    wsig(0, 2'h1);
    lock <= 0;
    wsig(0, 2'h2);
    lock <= 1;
    rd(8'h44);
    `CHK(q[8], 1'b1)
    wr(8'h00, 32'h0007_FC13);
    repeat (2) @(posedge clk);
    `CHK(power, 3'h3)
    rst_n <= 0;
    repeat (4) @(posedge clk);
    `CHK(chosen, 2'h0)
    stop_test();
  end
endmodule
